//--- design/temp_spi_map.svh
// offsets, field positions, reset values and timing counts of the setpoint port
`ifndef TEMP_SPI_MAP_SVH
`define TEMP_SPI_MAP_SVH
// sensor register addresses (command bits 5..3)
`define ADDR_STATUS 3'h0
`define ADDR_CONFIG 3'h1
`define ADDR_TEMP 3'h2
`define ADDR_IDENT 3'h3
`define ADDR_CRIT 3'h4
`define ADDR_HYST 3'h5
`define ADDR_UPPER 3'h6
`define ADDR_LOWER 3'h7
// power-on values
`define RST_CRIT 16'h4980
`define RST_HYST 4'h5
`define RST_UPPER 16'h2000
`define RST_LOWER 16'h0500
// command byte fields
`define CMD_LEAD_BIT 7
`define CMD_DIR_BIT 6
`define CMD_ADDR_HI 5
`define CMD_ADDR_LO 3
`define CMD_CONT_BIT 2
`define STREAM_CMD 8'h54
// serial framing
`define CMD_BITS 5'd8
`define NARROW_BITS 5'd8
`define WIDE_BITS 5'd16
`define GROUP_BITS 5'd16
`define ONES_RESET 6'd32
// one degree is 128 lsb of the temperature word
`define HYST_SHIFT 7
// controller register offsets
`define M_REG_CMD 3'h0
`define M_REG_TX 3'h1
`define M_REG_RX 3'h2
`define M_REG_STAT 3'h3
`define M_REG_SRST 3'h4
`define M_SKIP_BIT 8
// controller timing
`define SCLK_HALF 16'd8
`define CLK_MHZ 100
`define GUARD_US 500
`define GUARD_CYCLES (`GUARD_US * `CLK_MHZ)
`define SRST_BITS 6'd32
`endif

//--- design/temp_spi_pkg.sv
// types shared by both ends of the setpoint port
`default_nettype none
`include "temp_spi_map.svh"
package temp_spi_pkg;
  // sensor framing states, gray along cmd -> wr -> rd -> done
  typedef enum logic [2:0] {
    st_cmd = 3'b000,
    st_wr = 3'b001,
    st_rd = 3'b011,
    st_done = 3'b010,
    st_stream = 3'b110
  } sensor_state_e;
  // controller states, gray along idle -> lead -> shift -> trail
  typedef enum logic [2:0] {
    m_idle = 3'b000,
    m_lead = 3'b001,
    m_shift = 3'b011,
    m_trail = 3'b010,
    m_guard = 3'b110
  } master_state_e;
  // sixteen-bit registers of the sensor
  function automatic logic reg_is_wide(input logic [2:0] addr);
    reg_is_wide = (addr == `ADDR_TEMP) || (addr == `ADDR_CRIT) ||
                  (addr == `ADDR_UPPER) || (addr == `ADDR_LOWER);
  endfunction
endpackage
`default_nettype wire

//--- design/temp_spi_if.sv
// four-wire link between controller and sensor
`timescale 1ns/1ns
`default_nettype none
interface temp_spi_if;
  logic sclk; // serial clock, made by the controller
  logic cs_n; // chip select, active low
  logic mosi; // controller to sensor data
  logic miso; // sensor data output
  logic miso_oe_n; // sensor drives miso while low
  logic miso_line; // resolved wire, pulled up when released
  assign miso_line = miso_oe_n ? 1'b1 : miso;
  modport sensor(input sclk, input cs_n, input mosi, output miso, output miso_oe_n);
  modport master(output sclk, output cs_n, output mosi, input miso_line);
endinterface
`default_nettype wire

//--- design/sensor_end.sv
// sensor end: serial slave, setpoint registers and limit comparators
// Notes on behaviour
// - identification is read-only: maker code, revision
// - critical limit at 0x04, reset 0x4980
// - hysteresis at 0x05, four bits, reset 5
// - hysteresis lowers upper/critical, raises lower release
// - above upper limit raises limit alert
// - below lower limit raises limit alert
// - sample input rising, change output falling
// - master opens with select low, command byte
// - master keeps command lead and low bits zero
// - command bit 6: one reads, zero writes
// - bits 5..3 address one register per transaction
// - command 0x54 streams temperature every 16 clocks
// - write data 8/16 bits loads addressed register
// - master starts fresh transaction per write
// - first read bit on first falling edge
// - master ends reads with select high
// - select falling edge launches stream msb
// - select tied low gives three-wire operation
// - master idles serial clock high
// - 32 ones reset interface and registers
// - master waits 500 us after serial reset
// - temperature word readable at 0x02
// - interrupt mode: any read clears limit alert
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "temp_spi_map.svh"
module sensor_end
  import temp_spi_pkg::*;
#(
  parameter logic [4:0] MAKER_CODE = 5'h0a, // arbitrary value
  parameter logic [2:0] REVISION = 3'h1 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  temp_spi_if.sensor link,
  input wire logic [15:0] temperature_value,
  input wire logic interrupt_mode,
  output logic limit_alert,
  output logic critical_alert_pin,
  output logic interface_reset
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sclk_m, sclk_q, sclk_d; // serial clock: meta, stable, delayed
  logic cs_m, cs_q, cs_d; // chip select
  logic din_m, din_q; // serial input
  // the first stage of each chain feeds only its second stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {sclk_m, sclk_q, sclk_d} <= 3'h7;
      {cs_m, cs_q, cs_d} <= 3'h7;
      {din_m, din_q} <= 2'h0;
    end else begin
      sclk_m <= link.sclk;
      sclk_q <= sclk_m;
      sclk_d <= sclk_q;
      cs_m <= link.cs_n;
      cs_q <= cs_m;
      cs_d <= cs_q;
      din_m <= link.mosi;
      din_q <= din_m;
    end
  end
  // edges count only inside a frame; a grounded select keeps it open
  logic rise, fall, cs_fall;
  assign rise = sclk_q & ~sclk_d & ~cs_q;
  assign fall = ~sclk_q & sclk_d & ~cs_q;
  assign cs_fall = ~cs_q & cs_d;
  ////////////////////////////////////////////////////////////////////////////
  // serial reset detector
  logic [5:0] ones_reg; // consecutive ones seen on rising edges
  logic srst; // 32nd one in a row
  logic regs_init; // power-on or serial reset
  assign srst = rise & din_q & (ones_reg == `ONES_RESET - 6'd1);
  assign regs_init = ~reset_n | srst;
  always_ff @(posedge clk) begin
    if (regs_init) begin
      ones_reg <= 6'h0;
    end else if (rise) begin
      ones_reg <= din_q ? ones_reg + 6'd1 : 6'h0;
    end
  end
  // pulse to the user side, in the same cycle as the reset takes effect
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interface_reset <= 1'b0;
    end else begin
      interface_reset <= srst;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // framing
  sensor_state_e state_reg; // where the frame stands
  logic [4:0] count_reg; // rising edges within the current field
  logic [2:0] addr_reg; // addressed register of this transaction
  logic [15:0] in_reg; // input shifter
  logic seen_rise_reg; // a rising edge happened since select fell
  logic [7:0] cmd_byte; // command as it completes
  logic [15:0] wdata; // write word as it completes
  logic [4:0] data_bits; // width of the addressed register
  logic cmd_end, wr_end, rd_end, group_end, read_taken;
  assign cmd_byte = {in_reg[6:0], din_q};
  assign wdata = {in_reg[14:0], din_q};
  assign data_bits = reg_is_wide(addr_reg) ? `WIDE_BITS : `NARROW_BITS;
  assign cmd_end = rise & (state_reg == st_cmd) & (count_reg == `CMD_BITS - 5'd1);
  assign wr_end = rise & (state_reg == st_wr) & (count_reg == data_bits - 5'd1);
  assign rd_end = rise & (state_reg == st_rd) & (count_reg == data_bits - 5'd1);
  assign group_end = rise & (state_reg == st_stream) & (count_reg == `GROUP_BITS - 5'd1);
  assign read_taken = cmd_end & cmd_byte[`CMD_DIR_BIT];
  // input shifter runs on every rising edge in a frame
  always_ff @(posedge clk) begin
    if (regs_init) begin
      in_reg <= 16'h0;
    end else if (rise) begin
      in_reg <= wdata;
    end
  end
  // state and bit count; select high closes any frame but the stream
  always_ff @(posedge clk) begin
    if (regs_init) begin
      state_reg <= st_cmd;
      count_reg <= 5'h0;
      addr_reg <= 3'h0;
      seen_rise_reg <= 1'b0;
    end else if (cs_q) begin
      count_reg <= 5'h0;
      seen_rise_reg <= 1'b0;
      if (state_reg != st_stream) begin
        state_reg <= st_cmd;
      end
    end else if (rise) begin
      seen_rise_reg <= 1'b1;
      unique case (state_reg)
        st_cmd: begin
          if (cmd_end) begin
            count_reg <= 5'h0;
            addr_reg <= cmd_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
            if (cmd_byte == `STREAM_CMD) begin
              state_reg <= st_stream;
            end else if (cmd_byte[`CMD_DIR_BIT]) begin
              state_reg <= st_rd;
            end else begin
              state_reg <= st_wr;
            end
          end else begin
            count_reg <= count_reg + 5'd1;
          end
        end
        st_wr, st_rd: begin
          // one register only; extra clocks fall into done
          if (wr_end | rd_end) begin
            state_reg <= st_done;
          end else begin
            count_reg <= count_reg + 5'd1;
          end
        end
        st_stream: begin
          count_reg <= group_end ? 5'h0 : count_reg + 5'd1;
        end
        st_done: begin
        end
        default: begin
          state_reg <= st_cmd;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // setpoint registers
  logic [15:0] crit_reg; // critical limit
  logic [3:0] hyst_reg; // hysteresis in whole degrees
  logic [15:0] upper_reg; // upper limit
  logic [15:0] lower_reg; // lower limit
  // serial reset restores the same values as power-on
  always_ff @(posedge clk) begin
    if (regs_init) begin
      crit_reg <= `RST_CRIT;
      hyst_reg <= `RST_HYST;
      upper_reg <= `RST_UPPER;
      lower_reg <= `RST_LOWER;
    end else if (wr_end) begin
      unique case (addr_reg)
        `ADDR_CRIT: crit_reg <= wdata;
        `ADDR_HYST: hyst_reg <= wdata[3:0];
        `ADDR_UPPER: upper_reg <= wdata;
        `ADDR_LOWER: lower_reg <= wdata;
        default: begin
          // identification and absent registers keep their contents
        end
      endcase
    end
  end
  // read word, left aligned so eight-bit registers leave msb first
  function automatic logic [15:0] read_word(input logic [2:0] addr);
    unique case (addr)
      `ADDR_TEMP: read_word = temperature_value;
      `ADDR_IDENT: read_word = {MAKER_CODE, REVISION, 8'h00};
      `ADDR_CRIT: read_word = crit_reg;
      `ADDR_HYST: read_word = {4'h0, hyst_reg, 8'h00};
      `ADDR_UPPER: read_word = upper_reg;
      `ADDR_LOWER: read_word = lower_reg;
      default: read_word = 16'h0000;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // output shifter
  logic [15:0] out_reg; // bits still to be sent
  logic dout_reg; // level on the output pin
  // a falling edge before the first rising one in a frame is skipped, so a
  // master idling high and a frame-sync master both see the msb first
  always_ff @(posedge clk) begin
    if (regs_init) begin
      out_reg <= 16'h0;
      dout_reg <= 1'b0;
    end else if (cs_fall && state_reg == st_stream) begin
      dout_reg <= temperature_value[15];
      out_reg <= {temperature_value[14:0], 1'b0};
    end else if (read_taken) begin
      out_reg <= read_word(cmd_byte[`CMD_ADDR_HI:`CMD_ADDR_LO]);
    end else if (group_end) begin
      out_reg <= temperature_value;
    end else if (fall && seen_rise_reg) begin
      dout_reg <= out_reg[15];
      out_reg <= {out_reg[14:0], 1'b0};
    end
  end
  assign link.miso = dout_reg;
  assign link.miso_oe_n = cs_q; // released while deselected
  ////////////////////////////////////////////////////////////////////////////
  // limit comparators, 17-bit signed to keep the offsets from wrapping
  logic signed [16:0] t_s, up_s, lo_s, cr_s, h_s;
  assign t_s = {temperature_value[15], temperature_value};
  assign up_s = {upper_reg[15], upper_reg};
  assign lo_s = {lower_reg[15], lower_reg};
  assign cr_s = {crit_reg[15], crit_reg};
  assign h_s = {6'h00, hyst_reg, 7'h00};
  logic over, under, crit_over, over_clr, under_clr, crit_clr;
  assign over = t_s > up_s;
  assign under = t_s < lo_s;
  assign crit_over = t_s > cr_s;
  assign over_clr = t_s < (up_s - h_s);
  assign under_clr = t_s > (lo_s + h_s);
  assign crit_clr = t_s < (cr_s - h_s);
  logic high_reg, low_reg, crit_reg_state; // event states with hysteresis
  always_ff @(posedge clk) begin
    if (regs_init) begin
      high_reg <= 1'b0;
      low_reg <= 1'b0;
      crit_reg_state <= 1'b0;
    end else begin
      high_reg <= over | (high_reg & ~over_clr);
      low_reg <= under | (low_reg & ~under_clr);
      crit_reg_state <= crit_over | (crit_reg_state & ~crit_clr);
    end
  end
  // new event: limit crossed while its state was clear
  logic new_event;
  assign new_event = (over & ~high_reg) | (under & ~low_reg);
  // interrupt mode latches until a read; a fresh event beats the read
  always_ff @(posedge clk) begin
    if (regs_init) begin
      limit_alert <= 1'b0;
      critical_alert_pin <= 1'b0;
    end else begin
      critical_alert_pin <= crit_reg_state;
      if (!interrupt_mode) begin
        limit_alert <= high_reg | low_reg;
      end else if (new_event) begin
        limit_alert <= 1'b1;
      end else if (read_taken) begin
        limit_alert <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/master_end.sv
// controller end: register-driven serial master for the sensor
`timescale 1ns/1ns
`default_nettype none
`include "temp_spi_map.svh"
module master_end
  import temp_spi_pkg::*;
#(
  parameter logic [15:0] GUARD_CYCLES = 16'(`GUARD_CYCLES) // wait after serial reset
) (
  input wire logic clk,
  input wire logic reset_n,
  temp_spi_if.master link,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser; the first stage feeds only the second
  logic miso_m, miso_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      miso_m <= 1'b1;
      miso_q <= 1'b1;
    end else begin
      miso_m <= link.miso_line;
      miso_q <= miso_m;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  master_state_e state_reg;
  logic [15:0] phase_reg; // cycles within a half clock or the guard
  logic [5:0] bits_reg; // rising edges so far
  logic [5:0] total_reg; // rising edges in this transaction
  logic [31:0] tx_reg; // outgoing bits, msb first
  logic [15:0] shift_in_reg; // incoming bits
  logic srst_reg; // transaction is a serial reset
  logic sclk_reg, cs_n_reg, mosi_reg;
  logic [7:0] cmd_reg; // last command byte
  logic [15:0] txdata_reg; // write data
  logic [15:0] rx_reg; // last word read
  logic done_reg; // a transaction finished since status was read
  logic idle, start_cmd, start_srst, half_up, last_bit, wide;
  assign idle = (state_reg == m_idle);
  assign start_cmd = reg_write & idle & (reg_addr == `M_REG_CMD);
  assign start_srst = reg_write & idle & (reg_addr == `M_REG_SRST);
  assign half_up = (phase_reg == `SCLK_HALF - 16'd1);
  assign last_bit = (bits_reg == total_reg - 6'd1);
  assign wide = reg_is_wide(reg_wdata[`CMD_ADDR_HI:`CMD_ADDR_LO]);
  // each transaction carries at most one command and one register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= m_idle;
      phase_reg <= 16'h0;
      bits_reg <= 6'h0;
      total_reg <= 6'h0;
      tx_reg <= 32'h0;
      srst_reg <= 1'b0;
      cmd_reg <= 8'h0;
      sclk_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        m_idle: begin
          sclk_reg <= 1'b1;
          phase_reg <= 16'h0;
          bits_reg <= 6'h0;
          if (start_srst) begin
            state_reg <= m_lead;
            cs_n_reg <= 1'b0;
            srst_reg <= 1'b1;
            tx_reg <= 32'hffffffff;
            total_reg <= `SRST_BITS;
          end else if (start_cmd) begin
            state_reg <= m_lead;
            cs_n_reg <= 1'b0;
            srst_reg <= 1'b0;
            cmd_reg <= {1'b0, reg_wdata[6:2], 2'b00};
            if (reg_wdata[`M_SKIP_BIT]) begin
              tx_reg <= 32'h0; // stream group, no command byte
              total_reg <= {1'b0, `GROUP_BITS};
            end else if (wide) begin
              tx_reg <= {1'b0, reg_wdata[6:2], 2'b00, txdata_reg, 8'h00};
              total_reg <= {1'b0, `CMD_BITS + `WIDE_BITS};
            end else begin
              tx_reg <= {1'b0, reg_wdata[6:2], 2'b00, txdata_reg[7:0], 16'h0};
              total_reg <= {1'b0, `CMD_BITS + `NARROW_BITS};
            end
          end
        end
        m_lead: begin
          phase_reg <= half_up ? 16'h0 : phase_reg + 16'd1;
          if (half_up) begin
            state_reg <= m_shift;
            sclk_reg <= 1'b0;
            mosi_reg <= tx_reg[31];
            tx_reg <= {tx_reg[30:0], 1'b0};
          end
        end
        m_shift: begin
          phase_reg <= half_up ? 16'h0 : phase_reg + 16'd1;
          if (half_up && !sclk_reg) begin
            sclk_reg <= 1'b1; // device samples here
            bits_reg <= bits_reg + 6'd1;
            if (last_bit) begin
              state_reg <= m_trail;
            end
          end else if (half_up) begin
            sclk_reg <= 1'b0;
            mosi_reg <= tx_reg[31];
            tx_reg <= {tx_reg[30:0], 1'b0};
          end
        end
        m_trail: begin
          phase_reg <= half_up ? 16'h0 : phase_reg + 16'd1;
          if (half_up) begin
            cs_n_reg <= 1'b1;
            state_reg <= srst_reg ? m_guard : m_idle;
          end
        end
        m_guard: begin
          phase_reg <= phase_reg + 16'd1;
          if (phase_reg == GUARD_CYCLES - 16'd1) begin
            state_reg <= m_idle;
          end
        end
        default: begin
          state_reg <= m_idle;
        end
      endcase
    end
  end
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = mosi_reg;
  ////////////////////////////////////////////////////////////////////////////
  // receive side: sample the sensor on our own rising edges
  logic rise_now, finish;
  assign rise_now = (state_reg == m_shift) & half_up & ~sclk_reg;
  assign finish = (state_reg == m_trail) & half_up;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_in_reg <= 16'h0;
      rx_reg <= 16'h0;
    end else begin
      if (rise_now) begin
        shift_in_reg <= {shift_in_reg[14:0], miso_q};
      end
      if (finish && !srst_reg) begin
        rx_reg <= shift_in_reg;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // control registers; finishing beats a status read clearing done
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txdata_reg <= 16'h0;
      done_reg <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `M_REG_TX) begin
        txdata_reg <= reg_wdata;
      end
      if (finish) begin
        done_reg <= 1'b1;
      end else if (reg_read && reg_addr == `M_REG_STAT) begin
        done_reg <= 1'b0;
      end
    end
  end
  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0;
    end else if (reg_read) begin
      unique case (reg_addr)
        `M_REG_CMD: reg_rdata <= {8'h00, cmd_reg};
        `M_REG_TX: reg_rdata <= txdata_reg;
        `M_REG_RX: reg_rdata <= rx_reg;
        `M_REG_STAT: reg_rdata <= {13'h0, state_reg == m_guard, done_reg, ~idle};
        default: reg_rdata <= 16'h0;
      endcase
    end else begin
      reg_rdata <= 16'h0;
    end
  end
endmodule
`default_nettype wire

//--- sim/temp_spi_assertions.sv
// concurrent checks on the four-wire link between controller and sensor
`timescale 1ns/1ns
`default_nettype none
module temp_spi_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] since_fall; // cycles since a serial clock fall or select fall
  ////////////////////////////////////////////////////////////////////////////
  // saturating, so an output change far from any fall stands out
  always_ff @(posedge clk) begin
    if (!reset_n || $fell(sclk) || $fell(cs_n)) begin
      since_fall <= 4'h0;
    end else if (since_fall != 4'hf) begin
      since_fall <= since_fall + 4'h1;
    end
  end
  property p_miso_after_fall;
    !miso_oe_n && !$past(miso_oe_n) && $changed(miso) |-> since_fall < 4'h8;
  endproperty
  a_miso_after_fall: assert property (p_miso_after_fall)
    else $error("sensor output moved away from a clock fall");
  property p_miso_hold;
    $rose(sclk) && !miso_oe_n |=> $stable(miso)[*6];
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("sensor output not held while clock high");
  property p_sclk_idle;
    cs_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock low outside a frame");
  property p_select_lead;
    $fell(cs_n) |-> sclk[*7];
  endproperty
  a_select_lead: assert property (p_select_lead)
    else $error("clock fell too soon after select");
  property p_sclk_half;
    $fell(sclk) |-> !sclk[*8] ##1 sclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock low phase not 8 cycles");
  property p_mosi_on_fall;
    $changed(mosi) && !cs_n && !$past(cs_n) |-> $fell(sclk);
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall)
    else $error("controller data moved off a clock fall");
  property p_oe_follows;
    $fell(cs_n) |-> ##[1:5] !miso_oe_n;
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("sensor output not enabled after select");
  property p_oe_release;
    $rose(cs_n) |-> ##[1:5] miso_oe_n;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("sensor output not released after select");
endmodule
`default_nettype wire

//--- sim/tb.sv
// bench: controller and sensor joined, driven through the register port
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0; // 100 MHz
  logic reset_n = 1'b0; // held low 8 cycles
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] temperature_value = 16'h0c80; // inside all limits
  logic interrupt_mode = 1'b0; // comparator mode first
  logic limit_alert;
  logic critical_alert_pin;
  logic interface_reset;
  logic [15:0] d; // last word read
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic srst_seen = 1'b0; // interface reset pulse was seen
  temp_spi_if link();
  master_end #(.GUARD_CYCLES(16'd20)) master_end_inst (.clk, .reset_n, .link, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  // identification values are arbitrary
  sensor_end #(.MAKER_CODE(5'h13), .REVISION(3'h6)) sensor_end_inst (.clk, .reset_n, .link,
    .temperature_value, .interrupt_mode, .limit_alert, .critical_alert_pin, .interface_reset);
  temp_spi_assertions temp_spi_assertions_inst (.clk, .reset_n, .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n));
  always #5 clk = ~clk;
  // the reset pulse lasts one cycle, so latch it for a later compare
  always @(posedge clk) begin
    if (interface_reset === 1'b1) begin
      srst_seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // hang guard: the tests need well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // order a transfer, poll until neither busy nor guarding, fetch rx
  task go(input logic [2:0] a, input logic [15:0] v);
    int i;
    wr(a, v);
    for (i = 0; i < 600; i++) begin
      rd(3'h3);
      if (d[0] === 1'b0 && d[2] === 1'b0) break;
    end
    chk({15'h0, i == 600}, 16'h0000);
    rd(3'h2);
  endtask
  task xfer(input logic [15:0] cmd, input logic [15:0] tx);
    wr(3'h1, tx);
    go(3'h0, cmd);
  endtask
  task rdreg(input logic [2:0] a);
    xfer({8'h00, 2'b01, a, 3'b000}, 16'h0000);
  endtask
  task wreg(input logic [2:0] a, input logic [15:0] v);
    xfer({8'h00, 2'b00, a, 3'b000}, v);
  endtask
  // alerts are registered, so give them a few cycles
  task temp_to(input logic [15:0] t);
    @(posedge clk);
    temperature_value <= t;
    repeat (6) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rdreg(3'h4);
    chk(d, 16'h4980);
    rdreg(3'h5);
    chk(d & 16'h00ff, 16'h0005);
    rdreg(3'h6);
    chk(d, 16'h2000);
    rdreg(3'h7);
    chk(d, 16'h0500);
    rdreg(3'h3);
    chk(d & 16'h00ff, 16'h009e);
    rdreg(3'h2);
    chk(d, 16'h0c80);
    rd(3'h0);
    chk(d, 16'h0050);
    // writes land in one register only; read-only and unused bits hold
    wreg(3'h6, 16'h1234);
    rdreg(3'h6);
    chk(d, 16'h1234);
    rdreg(3'h7);
    chk(d, 16'h0500);
    wreg(3'h4, 16'h5a5a);
    rdreg(3'h4);
    chk(d, 16'h5a5a);
    wreg(3'h5, 16'h00fa);
    rdreg(3'h5);
    chk(d & 16'h00ff, 16'h000a);
    wreg(3'h3, 16'h0000);
    rdreg(3'h3);
    chk(d & 16'h00ff, 16'h009e);
    // stream command, then a bare 16-clock group in a later frame
    @(posedge clk) temperature_value <= 16'h1357;
    xfer(16'h0054, 16'h0000);
    chk(d, 16'h1357);
    @(posedge clk) temperature_value <= 16'h2468;
    xfer(16'h0100, 16'h0000);
    chk(d, 16'h2468);
    // 32 ones: stream ends and setpoints return to power-on values
    chk({15'h0, srst_seen}, 16'h0000);
    go(3'h4, 16'h0000);
    chk({15'h0, srst_seen}, 16'h0001);
    rdreg(3'h4);
    chk(d, 16'h4980);
    rdreg(3'h6);
    chk(d, 16'h2000);
    rdreg(3'h5);
    chk(d & 16'h00ff, 16'h0005);
    // comparator mode with 5 degree band (640 lsb)
    temp_to(16'h2080);
    chk({15'h0, limit_alert}, 16'h0001);
    temp_to(16'h1e00);
    chk({15'h0, limit_alert}, 16'h0001);
    temp_to(16'h1d00);
    chk({15'h0, limit_alert}, 16'h0000);
    temp_to(16'h0400);
    chk({15'h0, limit_alert}, 16'h0001);
    temp_to(16'h0600);
    chk({15'h0, limit_alert}, 16'h0001);
    temp_to(16'h4a00);
    chk({15'h0, critical_alert_pin}, 16'h0001);
    temp_to(16'h0c80);
    chk({15'h0, critical_alert_pin}, 16'h0000);
    // interrupt mode: a crossing sets, any read clears
    @(posedge clk) interrupt_mode <= 1'b1;
    temp_to(16'h2080);
    chk({15'h0, limit_alert}, 16'h0001);
    rdreg(3'h6);
    chk({15'h0, limit_alert}, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
